// ### core/rie_pkg.sv
// shared constants and types for the return instruction executor
package rie_pkg;
  // =====================================================
  // widths
  localparam int PC_W   = 13;
  localparam int DATA_W = 8;
  // =====================================================
  // irq control register layout
  localparam int IRQ_EN_BIT = 7;
  // =====================================================
  // timing: cycles taken by every return instruction
  localparam int RET_CYCLES = 2;
  // =====================================================
  // return kinds presented by the decoder
  typedef enum logic [1:0] {
    RIE_OP_NONE,
    RIE_OP_SUB_RETURN,
    RIE_OP_LITERAL_RETURN,
    RIE_OP_INTERRUPT_RETURN
  } rie_op_e;
  typedef enum logic {
    RIE_ST_IDLE,
    RIE_ST_FLUSH
  } rie_state_e;
endpackage : rie_pkg

// ### core/rie_cycle_counter.sv
// counter that times the cycles of a multi-cycle return
`timescale 1ns/1ps
module rie_cycle_counter
  import rie_pkg::*;
#(
  parameter int CYCLES = RET_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      last_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST_CNT = CW'(CYCLES - 1);
  logic [CW-1:0] count_ff;

  // =====================================================
  // count
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else if (start_i) begin
      count_ff <= CW'(1);
    end else if (count_ff == LAST_CNT) begin
      count_ff <= '0;
    end else if (count_ff != '0) begin
      count_ff <= count_ff + CW'(1);
    end
  end

  assign last_o = (count_ff == LAST_CNT);
endmodule : rie_cycle_counter

// ### core/rie_return_exec.sv
// executes the three return instructions of the core
// Notes on behaviour
// [RL1] interrupt return pops stack into pc
// [RL2] interrupt return sets global irq enable bit
// [RL3] interrupt return: two cycles, one word
// [RL4] literal return loads literal into w
// [RL5] literal return pops stack into pc
// [RL6] literal return: two cycles, flags untouched
// [RL7] plain return pops stack, nothing else
// [RL8] plain return takes two cycles
// [RL9] second cycle flushes prefetch, executes nop
`timescale 1ns/1ps
module rie_return_exec
  import rie_pkg::*;
#(
  parameter int PCW = PC_W,
  parameter int DW  = DATA_W
) (
  input  wire logic           clock_i,
  input  wire logic           rst_i,
  input  wire logic           op_valid_i,
  input  wire rie_op_e        op_i,
  input  wire logic [DW-1:0]  literal_i,
  input  wire logic [PCW-1:0] stack_top_i,
  output logic                busy_o,
  output logic                stack_pop_o,
  output logic                pc_load_o,
  output logic [PCW-1:0]      pc_value_o,
  output logic                w_load_o,
  output logic [DW-1:0]       w_value_o,
  output logic                global_irq_enable_set_o,
  output logic [DW-1:0]       irq_control_set_mask_o,
  output logic                prefetch_flush_o,
  output logic                done_o
);
  rie_state_e state_ff;
  logic       accept;
  logic       last;

  // new return accepted only when idle; one word, no operand fetch
  assign accept = op_valid_i && (op_i != RIE_OP_NONE) && (state_ff == RIE_ST_IDLE);

  // =====================================================
  // cycle timing
  // [RL3] two cycle sequence
  rie_cycle_counter #(
    .CYCLES (RET_CYCLES)
  ) u_count (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (accept),
    .last_o  (last)
  );

  // [RL8] second cycle lasts until counter ends
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= RIE_ST_IDLE;
    end else begin
      unique case (state_ff)
        RIE_ST_IDLE: begin
          if (accept) begin
            state_ff <= RIE_ST_FLUSH;
          end
        end
        RIE_ST_FLUSH: begin
          if (last) begin
            state_ff <= RIE_ST_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================
  // stack pop and pc load, shared by all three kinds
  // [RL1] pop stack top into pc
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stack_pop_o <= 1'b0;
      pc_load_o   <= 1'b0;
      pc_value_o  <= '0;
    end else begin
      // [RL5] [RL7] same pop for literal and plain returns
      stack_pop_o <= accept;
      pc_load_o   <= accept;
      if (accept) begin
        pc_value_o <= stack_top_i;
      end
    end
  end

  // =====================================================
  // working register
  // [RL4] literal into w; status flags never touched
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      w_load_o  <= 1'b0;
      w_value_o <= '0;
    end else begin
      w_load_o <= accept && (op_i == RIE_OP_LITERAL_RETURN);
      if (accept && (op_i == RIE_OP_LITERAL_RETURN)) begin
        w_value_o <= literal_i;
      end
    end
  end

  // =====================================================
  // interrupt enable
  // [RL2] set bit 7 of irq control register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      global_irq_enable_set_o <= 1'b0;
      irq_control_set_mask_o  <= '0;
    end else begin
      global_irq_enable_set_o <= accept && (op_i == RIE_OP_INTERRUPT_RETURN);
      irq_control_set_mask_o  <= '0;
      if (accept && (op_i == RIE_OP_INTERRUPT_RETURN)) begin
        irq_control_set_mask_o[IRQ_EN_BIT] <= 1'b1;
      end
    end
  end

  // =====================================================
  // second cycle
  // [RL9] discard prefetched word, run a nop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prefetch_flush_o <= 1'b0;
      busy_o           <= 1'b0;
      done_o           <= 1'b0;
    end else begin
      // [RL6] busy is high for one cycle only, the flush cycle after acceptance
      prefetch_flush_o <= accept;
      busy_o           <= accept || ((state_ff == RIE_ST_FLUSH) && !last);
      done_o           <= (state_ff == RIE_ST_FLUSH) && last;
    end
  end
endmodule : rie_return_exec

// ### tb/rie_return_exec_props.sv
// port assertions for the return instruction executor
`timescale 1ns/1ps
module rie_return_exec_props
  import rie_pkg::*;
#(parameter int PCW = PC_W, parameter int DW = DATA_W) (
  input wire logic clock_i, rst_i, op_valid_i, busy_o, stack_pop_o, pc_load_o, w_load_o,
  input wire logic global_irq_enable_set_o, prefetch_flush_o, done_o,
  input wire rie_op_e op_i,
  input wire logic [DW-1:0] literal_i, w_value_o, irq_control_set_mask_o,
  input wire logic [PCW-1:0] stack_top_i, pc_value_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // idle is the only state with busy low
  wire take = op_valid_i && op_i != RIE_OP_NONE && !busy_o;
  sequence pop_s; stack_pop_o && pc_load_o && pc_value_o == $past(stack_top_i); endsequence
  sequence ret_s; busy_o && prefetch_flush_o ##1 done_o && !busy_o; endsequence
  sequence irq_s; global_irq_enable_set_o && irq_control_set_mask_o == 8'h80; endsequence
  sequence w_s; w_load_o && w_value_o == $past(literal_i); endsequence
  pop_pc_a: assert property (take |=> pop_s)
    else $error("pop");
  two_cycle_a: assert property (take |=> ret_s)
    else $error("cycles");
  irq_set_a: assert property (take && op_i == RIE_OP_INTERRUPT_RETURN |=> irq_s)
    else $error("irq");
  irq_only_a: assert property (global_irq_enable_set_o |->
      $past(op_i) == RIE_OP_INTERRUPT_RETURN)
    else $error("irq kind");
  mask_zero_a: assert property (!global_irq_enable_set_o |-> irq_control_set_mask_o == 8'h00)
    else $error("mask");
  lit_w_a: assert property (take && op_i == RIE_OP_LITERAL_RETURN |=> w_s)
    else $error("w");
  w_only_a: assert property (w_load_o |-> $past(op_i) == RIE_OP_LITERAL_RETURN)
    else $error("w kind");
  flush_gap_a: assert property (busy_o |=> !stack_pop_o && !pc_load_o)
    else $error("refuse");
endmodule : rie_return_exec_props
bind rie_return_exec rie_return_exec_props #(.PCW(PCW), .DW(DW)) u_props (.*);

// ### tb/test_rie_return_exec.sv
// randomised bench for the return instruction executor
`timescale 1ns/1ps
module test_rie_return_exec
  import rie_pkg::*;
;
  logic clock_i = 0, rst_i = 1, op_valid_i = 0;
  rie_op_e op_i = RIE_OP_NONE;
  logic [DATA_W-1:0] literal_i = 8'h00, w_value_o, irq_control_set_mask_o;
  logic [PC_W-1:0] stack_top_i = 13'h0000, pc_value_o;
  logic busy_o, stack_pop_o, pc_load_o, w_load_o, global_irq_enable_set_o, prefetch_flush_o;
  logic done_o;
  int n_fail = 0, samples_checked = 0;
  always #2.5 clock_i = ~clock_i;
  rie_return_exec DUT (.*);
  function automatic logic [7:0] exp_mask(rie_op_e o);
    return (o == RIE_OP_INTERRUPT_RETURN) ? 8'h80 : 8'h00;
  endfunction : exp_mask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // ==========
  // one return, optionally followed by a request in the flush cycle
  task automatic ret(rie_op_e o, logic [7:0] k, logic [12:0] a, logic rf);
    logic [5:0] p;
    op_valid_i = 1;
    op_i = o;
    literal_i = k;
    stack_top_i = a;
    @(posedge clock_i);
    #1;
    p = {busy_o, stack_pop_o, pc_load_o, prefetch_flush_o, w_load_o, global_irq_enable_set_o};
    chk(16'(p), {10'h000, 4'hF, 1'(o == RIE_OP_LITERAL_RETURN), exp_mask(o)[7]});
    chk(16'(pc_value_o), 16'(a));
    chk(16'(irq_control_set_mask_o), 16'(exp_mask(o)));
    if (o == RIE_OP_LITERAL_RETURN) chk(16'(w_value_o), 16'(k));
    // decoder breaks spacing on purpose; must be ignored
    op_valid_i = rf;
    op_i = RIE_OP_INTERRUPT_RETURN;
    stack_top_i = ~a;
    @(posedge clock_i);
    #1;
    p = {done_o, busy_o, stack_pop_o, pc_load_o, prefetch_flush_o, global_irq_enable_set_o};
    chk(16'(p), 16'h0020);
    chk(16'(pc_value_o), 16'(a));
    $display("test op %0d done", o);
  endtask : ret
  initial begin
    void'($urandom(32'h1476));
    repeat (16) @(posedge clock_i);
    #1;
    rst_i = 0;
    for (int i = 1; i < 4; i++) ret(rie_op_e'(i), 8'hA5, 13'h1555, 0);
    ret(RIE_OP_LITERAL_RETURN, 8'h00, 13'h1FFF, 1);
    ret(RIE_OP_LITERAL_RETURN, 8'hFF, 13'h0000, 1);
    repeat (40) ret(rie_op_e'(1 + $urandom_range(2)), 8'($urandom), 13'($urandom), 1'($urandom));
    op_valid_i = 0;
    repeat (2) @(posedge clock_i);
    complete_run();
  end
  // about 120 cycles expected; forty times that is a hang
  initial begin
    #24000;
    n_fail++;
    complete_run();
  end
endmodule : test_rie_return_exec
